// ==== inc/irq_pkg.sv ====
package irq_pkg;

   // ****************************************************
   // Sizes, register map and reset values
   // ****************************************************
   localparam int         NUM_SRC        = 11;
   localparam int         NUM_GRP        = 6;
   localparam logic [7:0] PRIO_LOW_ADDR  = 8'ha9;
   localparam logic [7:0] PRIO_HIGH_ADDR = 8'hb9;
   localparam logic [5:0] PRIO_RESET     = 6'h00;

   // Source index equals polling position; group is index / 2
   localparam logic [3:0] SRC_EXT0 = 4'h0;
   localparam logic [3:0] SRC_SER1 = 4'h1;
   localparam logic [3:0] SRC_TMR0 = 4'h2;
   localparam logic [3:0] SRC_EXT2 = 4'h3;
   localparam logic [3:0] SRC_EXT1 = 4'h4;
   localparam logic [3:0] SRC_EXT3 = 4'h5;
   localparam logic [3:0] SRC_TMR1 = 4'h6;
   localparam logic [3:0] SRC_EXT4 = 4'h7;
   localparam logic [3:0] SRC_SER0 = 4'h8;
   localparam logic [3:0] SRC_EXT5 = 4'h9;
   localparam logic [3:0] SRC_EXT6 = 4'ha;

   // Sources held in a sticky flag; serial ones are live levels
   localparam logic [10:0] STICKY_MASK = 11'h6fd;

   typedef logic [15:0] vector_t;

   // Handler addresses
   localparam vector_t VEC_EXT0 = 16'h0003;
   localparam vector_t VEC_TMR0 = 16'h000b;
   localparam vector_t VEC_EXT1 = 16'h0013;
   localparam vector_t VEC_TMR1 = 16'h001b;
   localparam vector_t VEC_SER0 = 16'h0023;
   localparam vector_t VEC_SER1 = 16'h0083;
   localparam vector_t VEC_EXT2 = 16'h004b;
   localparam vector_t VEC_EXT3 = 16'h0053;
   localparam vector_t VEC_EXT4 = 16'h005b;
   localparam vector_t VEC_EXT5 = 16'h0063;
   localparam vector_t VEC_EXT6 = 16'h006b;

   // ****************************************************
   // Carriers
   // ****************************************************
   typedef struct packed {
      logic       valid;
      logic [3:0] src;
      logic [1:0] level;
      vector_t    vector;
   } irq_req_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_s;

   // ****************************************************
   // Decoders
   // ****************************************************
   function automatic vector_t vector_of(input logic [3:0] src);
      case (src)
         SRC_EXT0: vector_of = VEC_EXT0;
         SRC_SER1: vector_of = VEC_SER1;
         SRC_TMR0: vector_of = VEC_TMR0;
         SRC_EXT2: vector_of = VEC_EXT2;
         SRC_EXT1: vector_of = VEC_EXT1;
         SRC_EXT3: vector_of = VEC_EXT3;
         SRC_TMR1: vector_of = VEC_TMR1;
         SRC_EXT4: vector_of = VEC_EXT4;
         SRC_SER0: vector_of = VEC_SER0;
         SRC_EXT5: vector_of = VEC_EXT5;
         default:  vector_of = VEC_EXT6;
      endcase
   endfunction

   function automatic logic [1:0] level_of(input logic [5:0] lo,
                                           input logic [5:0] hi,
                                           input logic [3:0] src);
      level_of = {hi[src[3:1]], lo[src[3:1]]};
   endfunction

endpackage

// ==== rtl/interrupt_priority_vectoring.sv ====
// How it works
// R1 - External 0 and serial 1 form group 0; timer 0 and external 2 group 1.
// R2 - External 1 and 3 form group 2; timer 1 and external 4 group 3.
// R3 - Serial 0 and external 5 form group 4; external 6 alone group 5.
// R4 - Each group takes its level from bit x of both priority registers.
// R5 - Level is {high bit, low bit}: 00 lowest up to 11 highest.
// R6 - Equal levels are served in the fixed polling order, external 0 first.
// R7 - Software sets priorities once, before enabling any interrupt.
// R8 - External 0/1 and timers 0/1 vector to 0003, 0013, 000b, 001b.
// R9 - Serial 0 vectors to 0023, serial 1 to 0083; request is rx or tx.
// R10 - External 2 to 6 vector to 004b, 0053, 005b, 0063, 006b.
// R11 - External and timer flags clear by themselves when vectored.
// R12 - A source requests only while its enable bit is set.
// R13 - Higher level preempts a running handler; same or lower level waits.
module interrupt_priority_vectoring (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Special function register port
   input  wire irq_pkg::sfr_req_s sfr,
   output logic [7:0]             sfr_rdata,
   // Sources: set pulses, serial entries are rx|tx levels
   input  wire logic [10:0]       source_in,
   input  wire logic [10:0]       irq_enable,
   output logic [10:0]            pending_flags,
   // Processor core
   output irq_pkg::irq_req_s      irq_req,
   input  wire logic              irq_ack,
   input  wire logic              irq_return
);

   // ****************************************************
   // Reset release
   // ****************************************************
   logic       rst_meta;
   logic       rst_n;
   logic [5:0] prio_low_reg;
   logic [5:0] prio_high_reg;
   logic [10:0] flag_reg;
   logic [3:0]  in_svc_reg;
   logic [10:0] request;
   logic [10:0] clear_mask;
   logic [1:0]  src_level [irq_pkg::NUM_SRC];
   logic        best_found;
   logic [3:0]  best_src;
   logic [1:0]  best_lvl;
   logic        svc_valid;
   logic [1:0]  svc_lvl;
   irq_pkg::irq_req_s req_next;

   // Deassert synchronously so no flop leaves reset on a split edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ****************************************************
   // Priority registers
   // ****************************************************
   // Rewriting while interrupts run may reorder pending work
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prio_low_reg  <= irq_pkg::PRIO_RESET;
         prio_high_reg <= irq_pkg::PRIO_RESET;
      end else if (sfr.wr) begin
         if (sfr.addr == irq_pkg::PRIO_LOW_ADDR)
            prio_low_reg <= sfr.wdata[5:0];                  // see R4
         if (sfr.addr == irq_pkg::PRIO_HIGH_ADDR)
            prio_high_reg <= sfr.wdata[5:0];                 // see R4
      end
   end

   // Other addresses answer zero so the core can OR read buses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr.rd && sfr.addr == irq_pkg::PRIO_LOW_ADDR) begin
         sfr_rdata <= {2'b00, prio_low_reg};
      end else if (sfr.rd && sfr.addr == irq_pkg::PRIO_HIGH_ADDR) begin
         sfr_rdata <= {2'b00, prio_high_reg};
      end else begin
         sfr_rdata <= 8'h00;
      end
   end

   // ****************************************************
   // Request flags
   // ****************************************************
   // Only the vector actually taken is cleared
   assign clear_mask = irq_ack ? ((11'h001 << irq_req.src) &
                                  irq_pkg::STICKY_MASK) : 11'h000;

   // Set is ORed last, so an event on the clearing edge survives
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_reg <= 11'h000;
      end else begin
         flag_reg <= (flag_reg & ~clear_mask) |              // see R11
                     (source_in & irq_pkg::STICKY_MASK);
      end
   end

   // Serial channels bypass the flags and follow their rx|tx level
   assign request = ((flag_reg & irq_pkg::STICKY_MASK) |
                     (source_in & ~irq_pkg::STICKY_MASK))    // see R9
                    & irq_enable;                            // see R12

   // Flags of the sticky sources, for the core's status view
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         pending_flags <= 11'h000;
      else
         pending_flags <= flag_reg;
   end

   // ****************************************************
   // Arbitration
   // ****************************************************
   // Group membership follows from the polling index
   for (genvar g = 0; g < irq_pkg::NUM_SRC; g++) begin : gen_level
      assign src_level[g] = irq_pkg::level_of(prio_low_reg,  // see R1 R2 R3 R5
                                              prio_high_reg, 4'(g));
   end

   // Scan from the back so the earliest index wins a tie
   always_comb begin
      best_found = 1'b0;
      best_src   = 4'h0;
      best_lvl   = 2'b00;
      for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (request[i] && (!best_found || src_level[i] >= best_lvl)) begin
            best_found = 1'b1;                               // see R6
            best_src   = 4'(i);
            best_lvl   = src_level[i];
         end
      end
   end

   // Highest level currently in service
   always_comb begin
      svc_valid = |in_svc_reg;
      svc_lvl   = 2'b00;
      for (int l = 0; l < 4; l++) begin
         if (in_svc_reg[l])
            svc_lvl = 2'(l);
      end
   end

   // Offer drops for one cycle after an ack so it is not taken twice
   always_comb begin
      req_next.valid  = best_found && !irq_ack &&
                        (!svc_valid || best_lvl > svc_lvl);  // see R13
      req_next.src    = best_src;
      req_next.level  = best_lvl;
      req_next.vector = irq_pkg::vector_of(best_src);        // see R8 R9 R10
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         irq_req <= '0;
      else
         irq_req <= req_next;
   end

   // ****************************************************
   // In-service levels
   // ****************************************************
   // One bit per level; a return closes the highest open one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_svc_reg <= 4'h0;
      end else if (irq_ack) begin
         in_svc_reg <= in_svc_reg | (4'h1 << irq_req.level); // see R13
      end else if (irq_return && svc_valid) begin
         in_svc_reg <= in_svc_reg & ~(4'h1 << svc_lvl);
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   group_level_a: assert property (@(posedge clk) disable iff (!rst_n)
      irq_req.valid |->                                      // see R1 R2 R3 R4 R5
         irq_req.level ==
            {1'($past(prio_high_reg) >> irq_req.src[3:1]),
             1'($past(prio_low_reg) >> irq_req.src[3:1])})
      else $error("request level does not match its group");

   tie_order_a: assert property (@(posedge clk) disable iff (!rst_n)
      $past(request[0]) && irq_req.valid |->                 // see R6
         irq_req.src == irq_pkg::SRC_EXT0 ||
         irq_req.level > $past(src_level[0]))
      else $error("polling order broken on a tie");

   ext0_vector_a: assert property (@(posedge clk) disable iff (!rst_n)
      irq_req.valid && irq_req.src == irq_pkg::SRC_EXT0 |->  // see R8
         irq_req.vector == irq_pkg::VEC_EXT0)
      else $error("wrong vector for external 0");

   ser1_vector_a: assert property (@(posedge clk) disable iff (!rst_n)
      irq_req.valid && irq_req.src == irq_pkg::SRC_SER1 |->  // see R9
         irq_req.vector == irq_pkg::VEC_SER1)
      else $error("wrong vector for serial 1");

   ext6_vector_a: assert property (@(posedge clk) disable iff (!rst_n)
      irq_req.valid && irq_req.src == irq_pkg::SRC_EXT6 |->  // see R10
         irq_req.vector == irq_pkg::VEC_EXT6)
      else $error("wrong vector for external 6");

   flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      irq_ack && irq_pkg::STICKY_MASK[irq_req.src] &&
      !source_in[irq_req.src] |=>                            // see R11
         !flag_reg[$past(irq_req.src)])
      else $error("flag not cleared on vector");

   enable_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      irq_req.valid |-> 1'($past(irq_enable) >> irq_req.src))  // see R12
      else $error("request from a disabled source");

   preempt_only_a: assert property (@(posedge clk) disable iff (!rst_n)
      irq_req.valid && $past(svc_valid) |->                  // see R13
         irq_req.level > $past(svc_lvl))
      else $error("request does not outrank running handler");

   ack_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
      irq_ack |=> !irq_req.valid &&                          // see R13
         in_svc_reg[$past(irq_req.level)])
      else $error("offer not withdrawn after ack");

endmodule

// ==== verif/core_model.sv ====
module core_model (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Bench control
   input  wire logic              go,
   input  wire logic [2:0]        ack_wait,
   input  wire logic [5:0]        run_len,
   // Controller side
   input  wire irq_pkg::irq_req_s req,
   output logic                   ack,
   output logic                   ret,
   output logic [2:0]             depth
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************
   // Processor core taking vectors and running handlers
   // ****************************************************
   logic [2:0] quiet_reg;
   logic [5:0] busy_reg;

   // Quiet time, so an offer is only taken once it has settled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) quiet_reg <= 3'h0;
      else if (!go || ack || ret) quiet_reg <= 3'h0;
      else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
   end

   // Take offers, run handlers, return innermost first; never both at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {ack, ret, depth, busy_reg} <= '0;
      end else begin
         ack <= 1'b0;
         ret <= 1'b0;
         if (go && req.valid && !ack && !ret && quiet_reg >= ack_wait) begin
            ack <= 1'b1;
            depth <= depth + 3'h1;
            busy_reg <= 6'h0;
         end else if (depth != 3'h0 && busy_reg >= run_len) begin
            ret <= 1'b1;
            depth <= depth - 3'h1;
            busy_reg <= 6'h0;
         end else if (depth != 3'h0) begin
            busy_reg <= busy_reg + 6'h1;
         end
      end
   end
endmodule

// ==== verif/interrupt_priority_vectoring_tb.sv ====
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module interrupt_priority_vectoring_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset_n, go, irq_ack, irq_return;
   irq_pkg::sfr_req_s sfr;
   irq_pkg::irq_req_s irq_req;
   logic [10:0] src_p, ser, en, pending_flags, mflag;
   logic [7:0]  sfr_rdata;
   logic [5:0]  lo, hi, run_len;
   logic [3:0]  isv;
   logic [2:0]  ack_wait, depth;
   logic [31:0] seed, r;
   int          fails, tests_run;
   logic [2:0]  grp [11] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5};
   logic [15:0] vec [11] = '{16'h0003, 16'h0083, 16'h000b, 16'h004b,
      16'h0013, 16'h0053, 16'h001b, 16'h005b, 16'h0023, 16'h0063, 16'h006b};

   // ****************************************************
   // Design, core model and reference model
   // ****************************************************
   interrupt_priority_vectoring interrupt_priority_vectoring_i (
      .clk(clk), .reset_n(reset_n), .sfr(sfr), .sfr_rdata(sfr_rdata),
      .source_in(src_p | ser), .irq_enable(en),
      .pending_flags(pending_flags), .irq_req(irq_req),
      .irq_ack(irq_ack), .irq_return(irq_return));
   core_model core_model_i (
      .clk(clk), .rst_n(reset_n), .go(go), .ack_wait(ack_wait),
      .run_len(run_len), .req(irq_req), .ack(irq_ack), .ret(irq_return),
      .depth(depth));

   function automatic logic [1:0] lvl(input int i);
      lvl = {hi[grp[i]], lo[grp[i]]};
   endfunction
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      rnd = seed;
   endfunction
   // Winner: highest level above the in-service one, lowest index on ties
   function automatic logic [3:0] best();
      int t;
      logic [10:0] q;
      t = -1;
      q = (mflag | ser) & en;
      best = 4'hf;
      for (int l = 0; l < 4; l++) if (isv[l]) t = l;
      for (int i = 10; i >= 0; i--)
         if (q[i] && int'(lvl(i)) > t && (best == 4'hf || lvl(i) >= lvl(best)))
            best = 4'(i);
   endfunction

   // Every vector taken is checked, then the model retires it
   always @(posedge clk) begin
      logic [3:0] b;
      if (irq_ack === 1'b1) begin
         b = best();
         `CHK("src", b, irq_req.src)
         if (b != 4'hf) begin
            `CHK("vector", vec[b], irq_req.vector)
            `CHK("level", lvl(b), irq_req.level)
            mflag[b] = 1'b0;
            ser[b] <= 1'b0;
            isv[lvl(b)] = 1'b1;
         end
      end
      if (irq_return === 1'b1)
         for (int l = 3; l >= 0; l--) if (isv[l]) begin
            isv[l] = 1'b0;
            break;
         end
   end

   // ****************************************************
   // Stimulus tasks
   // ****************************************************
   task automatic sfr_io(input logic w, input logic [7:0] a,
                         input logic [7:0] d);
      @(posedge clk);
      sfr <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      sfr <= '0;
      #1;
   endtask
   // Core held off while sources and enables change, so offers settle
   task automatic stim(input logic [10:0] m, input logic [10:0] e);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      src_p <= m & irq_pkg::STICKY_MASK;
      ser <= ser | (m & ~irq_pkg::STICKY_MASK);
      mflag = mflag | (m & irq_pkg::STICKY_MASK);
      en <= e;
      @(posedge clk);
      src_p <= '0;
      repeat (3) @(posedge clk);
      go <= 1'b1;
   endtask
   task automatic drain();
      int n;
      n = 0;
      go <= 1'b1;
      while ((depth != 0 || isv != 0 || best() != 4'hf) && n < 3000) begin
         @(posedge clk);
         n++;
      end
      `CHK("drain", 1'b1, n < 3000)
      repeat (4) @(posedge clk);
      #1;
      `CHK("valid", 1'b0, irq_req.valid)
      `CHK("flags", mflag, pending_flags)
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      close_out();
   end
   initial begin
      {reset_n, go, src_p, ser, en, mflag, isv, lo, hi} = '0;
      sfr = '0;
      ack_wait = 3'h2;
      run_len = 6'h4;
      seed = 32'h5d9e;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      sfr_io(1'b0, irq_pkg::PRIO_LOW_ADDR, 8'h00);
      `CHK("low reset", 8'h00, sfr_rdata)
      sfr_io(1'b1, irq_pkg::PRIO_HIGH_ADDR, 8'hff);
      sfr_io(1'b0, irq_pkg::PRIO_HIGH_ADDR, 8'h00);
      `CHK("high rw", 8'h3f, sfr_rdata)
      sfr_io(1'b1, 8'hb8, 8'h15);
      sfr_io(1'b0, 8'hb8, 8'h00);
      `CHK("unmapped", 8'h00, sfr_rdata)
      sfr_io(1'b0, irq_pkg::PRIO_HIGH_ADDR, 8'h00);
      `CHK("high kept", 8'h3f, sfr_rdata)
      sfr_io(1'b1, irq_pkg::PRIO_HIGH_ADDR, 8'h00);
      $display("test registers done");
      // All eleven at one level: served strictly in polling order
      stim(11'h7ff, 11'h7ff);
      drain();
      $display("test polling order done");
      for (int i = 0; i < 60; i++) begin
         r = rnd();
         if (i % 4 == 0) begin
            stim(11'h0, 11'h0);
            sfr_io(1'b1, irq_pkg::PRIO_LOW_ADDR, r[7:0]);
            sfr_io(1'b1, irq_pkg::PRIO_HIGH_ADDR, r[15:8]);
            lo = r[5:0];
            hi = r[13:8];
            sfr_io(1'b0, irq_pkg::PRIO_LOW_ADDR, 8'h00);
            `CHK("low rw", {2'b00, lo}, sfr_rdata)
         end
         ack_wait <= 3'h2 + {1'b0, r[17:16]};
         run_len <= r[23:18];
         stim(rnd() & 11'h7ff, (rnd() | rnd()) & 11'h7ff);
         if (i % 4 == 3) drain();
         else repeat (20) @(posedge clk);
         $display("test random %0d done", i);
      end
      close_out();
   end
endmodule
